// ### core/cpp_channel_port.sv
// Channel parallel port: CPU-style FIFO, bit-bang modes and activity lights.
`include "cpp_consts.svh"
module cpp_channel_port import cpp_pkg::*; #(
	parameter int LED_HOLD_CYCLES = `CPP_LED_HOLD_CYCLES
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Start-up configuration: high selects CPU-style FIFO mode.
	input wire logic cfg_cpu_fifo_in,
	// Host-to-pins byte stream.
	input wire logic h2d_valid_in,
	input wire logic [7:0] h2d_data_in,
	output logic h2d_take_out,
	// Pins-to-host byte stream.
	input wire logic d2h_space_in,
	output logic d2h_valid_out,
	output logic [7:0] d2h_data_out,
	output logic send_immediate_out,
	// Mode-select command from the host.
	input wire logic mode_cmd_valid_in,
	input wire logic [7:0] mode_cmd_value_in,
	input wire logic [7:0] mode_cmd_mask_in,
	// Channel timing and USB state.
	input wire logic baud_tick_in,
	input wire logic suspended_in,
	input wire logic configured_in,
	// UART activity from the serial engine.
	input wire logic uart_tx_active_in,
	input wire logic uart_rx_active_in,
	// CPU-style FIFO control pins.
	input wire logic port_select_n_in,
	input wire logic register_select_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic flush_wake_n_in,
	// Parallel data pins.
	input wire logic [7:0] pins_in,
	output logic [7:0] pins_out,
	output logic [7:0] pins_oe_out,
	// Bit-bang strobes.
	output logic pin_sample_strobe_n_out,
	output logic pin_update_strobe_n_out,
	// Activity lights, driven low while active.
	output logic tx_led_out,
	output logic tx_led_oe_out,
	output logic rx_led_out,
	output logic rx_led_oe_out,
	// Current mode.
	output cpp_mode_type mode_out
);

	typedef struct packed {
		logic strap_done;
		logic base_cpu;
		cpp_mode_type mode;
		logic [7:0] dir;
		logic [7:0] dout;
		logic cpu_drive;
		logic read_prev;
		logic write_prev;
		logic flush_prev;
		cpp_bb_type bb;
		logic [7:0] held;
		logic h2d_take;
		logic d2h_valid;
		logic [7:0] d2h_data;
		logic flush;
		logic sample_n;
		logic update_n;
		logic [7:0] oe;
	} cpp_state_type;

	cpp_state_type s_q;
	cpp_state_type s_d;
	logic rx_ready;
	logic cpu_sel;
	logic [7:0] status;

	cpp_led_if leds[2] ();

	// Status byte; the upper nibble is unused and reads as zero.
	function automatic logic [7:0] status_byte(input logic rx, input logic tx,
			input logic susp, input logic cfg);
		logic [7:0] b;
		b = 8'h00;
		b[`CPP_STAT_RX_AVAIL] = rx;
		b[`CPP_STAT_TX_SPACE] = tx;
		b[`CPP_STAT_SUSPEND] = susp;
		b[`CPP_STAT_CONFIGURED] = cfg;
		return b;
	endfunction

	// A host byte counts as present only once the previous take has settled.
	assign rx_ready = h2d_valid_in && !s_q.h2d_take;
	assign cpu_sel = (s_q.mode == CPP_MODE_CPU_FIFO) && !port_select_n_in;
	assign status = status_byte(rx_ready, d2h_space_in, suspended_in,
		configured_in);

	// Next-state logic for every mode of the channel.
	always_comb begin
		s_d = s_q;
		s_d.h2d_take = 1'b0;
		s_d.d2h_valid = 1'b0;
		s_d.flush = 1'b0;
		s_d.read_prev = read_n_in;
		s_d.write_prev = write_n_in;
		s_d.flush_prev = flush_wake_n_in;

		// The strap is caught once after reset release, never at run time.
		if (!s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			s_d.base_cpu = cfg_cpu_fifo_in;
			s_d.mode = cfg_cpu_fifo_in ? CPP_MODE_CPU_FIFO : CPP_MODE_UART;
		end else if (mode_cmd_valid_in) begin
			// Unknown command values are ignored and leave the mode alone.
			if (mode_cmd_value_in == `CPP_MODE_CMD_ASYNC) begin
				s_d.mode = CPP_MODE_ASYNC_BB;
				s_d.dir = mode_cmd_mask_in;
			end else if (mode_cmd_value_in == `CPP_MODE_CMD_SYNC) begin
				s_d.mode = CPP_MODE_SYNC_BB;
				s_d.dir = mode_cmd_mask_in;
			end else if (mode_cmd_value_in == `CPP_MODE_CMD_RESET) begin
				s_d.mode = s_q.base_cpu ? CPP_MODE_CPU_FIFO : CPP_MODE_UART;
				s_d.dir = 8'h00;
			end
			s_d.bb = CPP_BB_IDLE;
			s_d.sample_n = 1'b0;
			s_d.update_n = 1'b1;
		end

		// Flush pin: a falling edge asks for send-immediate in any mode.
		if (s_q.flush_prev && !flush_wake_n_in) begin
			s_d.flush = 1'b1;
		end

		case (s_q.mode)
			CPP_MODE_CPU_FIFO: begin
				// Strobes count only while port-select is low.
				s_d.cpu_drive = cpu_sel && !read_n_in;
				if (cpu_sel && s_q.read_prev && !read_n_in) begin
					if (register_select_in == `CPP_RS_DATA) begin
						s_d.dout = h2d_data_in;
						s_d.h2d_take = rx_ready;
					end else begin
						s_d.dout = status;
					end
				end
				// Writes land on the rising edge, when bus data has settled.
				if (cpu_sel && !s_q.write_prev && write_n_in) begin
					if (register_select_in == `CPP_RS_DATA) begin
						s_d.d2h_valid = d2h_space_in;
						s_d.d2h_data = pins_in;
					end else begin
						s_d.flush = 1'b1;
					end
				end
			end
			CPP_MODE_ASYNC_BB: begin
				s_d.cpu_drive = 1'b0;
				s_d.sample_n = 1'b1;
				s_d.update_n = 1'b1;
				// A baud tick with host-bound room samples the pins; a new byte also drives.
				if (baud_tick_in) begin
					if (d2h_space_in) begin
						s_d.sample_n = 1'b0;
						s_d.d2h_valid = 1'b1;
						s_d.d2h_data = pins_in;
					end
					if (rx_ready) begin
						s_d.h2d_take = 1'b1;
						s_d.dout = h2d_data_in;
						s_d.update_n = 1'b0;
					end
				end
			end
			CPP_MODE_SYNC_BB: begin
				s_d.cpu_drive = 1'b0;
				case (s_q.bb)
					CPP_BB_IDLE: begin
						// Both a byte and host-bound room are needed to start.
						if (rx_ready && d2h_space_in) begin
							s_d.held = h2d_data_in;
							s_d.h2d_take = 1'b1;
							s_d.d2h_valid = 1'b1;
							s_d.d2h_data = pins_in;
							s_d.sample_n = 1'b1;
							s_d.bb = CPP_BB_DRIVE;
						end
					end
					CPP_BB_DRIVE: begin
						s_d.sample_n = 1'b0;
						s_d.dout = s_q.held;
						s_d.bb = CPP_BB_SETUP;
					end
					CPP_BB_SETUP: begin
						s_d.update_n = 1'b0;
						s_d.bb = CPP_BB_UPDATE;
					end
					CPP_BB_UPDATE: begin
						s_d.update_n = 1'b1;
						s_d.bb = CPP_BB_END;
					end
					CPP_BB_END: begin
						s_d.bb = CPP_BB_IDLE;
					end
					default: begin
						s_d.bb = CPP_BB_IDLE;
					end
				endcase
			end
			default: begin
				s_d.cpu_drive = 1'b0;
			end
		endcase

		// Pin enables are registered so the pad buffers never see a decode
		// glitch; a bit-bang mode owns the pins even on its first cycle.
		if (s_d.mode == CPP_MODE_ASYNC_BB || s_d.mode == CPP_MODE_SYNC_BB) begin
			s_d.oe = s_d.dir;
		end else if (s_d.cpu_drive) begin
			s_d.oe = 8'hFF;
		end else begin
			s_d.oe = 8'h00;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
			s_q.mode <= CPP_MODE_UART;
			s_q.bb <= CPP_BB_IDLE;
			s_q.update_n <= 1'b1;
			s_q.flush_prev <= 1'b1;
			s_q.read_prev <= 1'b1;
			s_q.write_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Activity feeds: lights work only in UART mode.
	assign leds[0].activity = (s_q.mode == CPP_MODE_UART) && uart_tx_active_in;
	assign leds[1].activity = (s_q.mode == CPP_MODE_UART) && uart_rx_active_in;

	// One retriggerable stretcher per light.
	generate
		for (genvar i = 0; i < 2; i++) begin : g_led
			cpp_led_stretch #(
				.HOLD_CYCLES(LED_HOLD_CYCLES)
			) u_led (
				.clk_in(clk_in),
				.reset_n_in(reset_n_in),
				.led(leds[i])
			);
		end
	endgenerate

	// Outputs; light pins only ever pull low, never drive high.
	assign tx_led_out = 1'b0;
	assign rx_led_out = 1'b0;
	assign tx_led_oe_out = leds[0].drive;
	assign rx_led_oe_out = leds[1].drive;
	assign h2d_take_out = s_q.h2d_take;
	assign d2h_valid_out = s_q.d2h_valid;
	assign d2h_data_out = s_q.d2h_data;
	assign send_immediate_out = s_q.flush;
	assign pins_out = s_q.dout;
	assign pins_oe_out = s_q.oe;
	assign pin_sample_strobe_n_out = s_q.sample_n;
	assign pin_update_strobe_n_out = s_q.update_n;
	assign mode_out = s_q.mode;

endmodule // cpp_channel_port

// ### core/cpp_consts.svh
// Constants for the channel parallel port: command codes, status bits, times.
`ifndef CPP_CONSTS_SVH
`define CPP_CONSTS_SVH

// Mode-select command values.
`define CPP_MODE_CMD_RESET 8'h00
`define CPP_MODE_CMD_ASYNC 8'h01
`define CPP_MODE_CMD_SYNC 8'h04

// Status byte bit positions.
`define CPP_STAT_RX_AVAIL 0
`define CPP_STAT_TX_SPACE 1
`define CPP_STAT_SUSPEND 2
`define CPP_STAT_CONFIGURED 3

// Register-select values in CPU-style FIFO mode.
`define CPP_RS_DATA 1'b0
`define CPP_RS_STATUS 1'b1

// Clock and activity light stretch time.
`define CPP_CLK_PERIOD_NS 40
`define CPP_LED_HOLD_NS 10000000
`define CPP_LED_HOLD_CYCLES (`CPP_LED_HOLD_NS / `CPP_CLK_PERIOD_NS)

`endif

// ### core/cpp_pkg.sv
// Types shared by the channel parallel port modules.
package cpp_pkg;

	// Operating mode of the channel.
	typedef enum logic [1:0] {
		CPP_MODE_UART,
		CPP_MODE_CPU_FIFO,
		CPP_MODE_ASYNC_BB,
		CPP_MODE_SYNC_BB
	} cpp_mode_type;

	// Synchronous bit-bang transfer sequence.
	typedef enum logic [2:0] {
		CPP_BB_IDLE,
		CPP_BB_DRIVE,
		CPP_BB_SETUP,
		CPP_BB_UPDATE,
		CPP_BB_END
	} cpp_bb_type;

endpackage

// ### core/cpp_led_if.sv
// Carrier between the port core and an activity light stretcher.
interface cpp_led_if;
	logic activity;
	logic drive;

	modport core (output activity, input drive);
	modport stretch (input activity, output drive);
endinterface

// ### core/cpp_led_stretch.sv
// One-shot timer that stretches brief activity into a visible light pulse.
module cpp_led_stretch import cpp_pkg::*; #(
	parameter int HOLD_CYCLES = 250000
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Link to the core.
	cpp_led_if.stretch led
);

	typedef struct packed {
		logic [31:0] count;
		logic drive;
	} cpp_led_state_type;

	cpp_led_state_type s_q;
	cpp_led_state_type s_d;

	// Each activity pulse retriggers the timer, so steady traffic stays lit.
	always_comb begin
		s_d = s_q;
		if (led.activity) begin
			s_d.count = 32'(HOLD_CYCLES);
			s_d.drive = 1'b1;
		end else if (s_q.count != 32'h0) begin
			s_d.count = s_q.count - 32'h1;
			s_d.drive = (s_q.count != 32'h1);
		end else begin
			s_d.drive = 1'b0;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign led.drive = s_q.drive;

endmodule // cpp_led_stretch

// ### sim/cpp_channel_port_sva.sv
// Assertion checker for the channel parallel port bus, pipes and strobes.
module cpp_channel_port_sva import cpp_pkg::*; (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Host side streams and commands.
	input wire logic h2d_valid_in,
	input wire logic [7:0] h2d_data_in,
	input wire logic h2d_take_out,
	input wire logic d2h_space_in,
	input wire logic d2h_valid_out,
	input wire logic [7:0] d2h_data_out,
	input wire logic send_immediate_out,
	input wire logic mode_cmd_valid_in,
	input wire logic [7:0] mode_cmd_value_in,
	input wire logic [7:0] mode_cmd_mask_in,
	input wire logic baud_tick_in,
	// Pin side.
	input wire logic port_select_n_in,
	input wire logic register_select_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic [7:0] pins_in,
	input wire logic [7:0] pins_out,
	input wire logic [7:0] pins_oe_out,
	input wire logic pin_sample_strobe_n_out,
	input wire logic pin_update_strobe_n_out,
	input wire cpp_mode_type mode_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	// Mode and decode shorthands keep the properties readable.
	wire cpu = mode_out == CPP_MODE_CPU_FIFO;
	wire sel = !port_select_n_in;
	wire sync = mode_out == CPP_MODE_SYNC_BB;

	// A deselected port must never move data, whatever the strobes do.
	idle_cs_a: assert property (cpu && $past(port_select_n_in)
		|-> !h2d_take_out && !d2h_valid_out) else $error("deselected access");
	pop_data_a: assert property (cpu && $fell(read_n_in) && sel
		&& !register_select_in && h2d_valid_in
		|=> h2d_take_out && pins_out == $past(h2d_data_in))
		else $error("data read wrong");
	push_data_a: assert property (cpu && $rose(write_n_in) && sel
		&& !register_select_in && d2h_space_in
		|=> d2h_valid_out && d2h_data_out == $past(pins_in))
		else $error("data write lost");
	flush_req_a: assert property (cpu && $rose(write_n_in) && sel
		&& register_select_in |=> send_immediate_out && !d2h_valid_out)
		else $error("flush missing");
	// Sample first, then new outputs, then update low the next cycle, then high again.
	sync_walk_a: assert property (sync && h2d_take_out
		|-> d2h_valid_out && pin_sample_strobe_n_out
		##1 !pin_sample_strobe_n_out && pins_out == $past(h2d_data_in)
		##1 !pin_update_strobe_n_out ##1 pin_update_strobe_n_out)
		else $error("sync sequence wrong");
	sync_room_a: assert property (sync && !$past(d2h_space_in)
		|-> !h2d_take_out) else $error("byte taken without room");
	async_hold_a: assert property (mode_out == CPP_MODE_ASYNC_BB
		&& $past(mode_out) == CPP_MODE_ASYNC_BB && !$past(baud_tick_in)
		|-> $stable(pins_out)) else $error("pins moved without tick");
	async_strobe_a: assert property ($past(mode_out) == CPP_MODE_ASYNC_BB
		&& $past(baud_tick_in) && $past(d2h_space_in)
		|-> !pin_sample_strobe_n_out && d2h_valid_out)
		else $error("async sample strobe missing");
	mode_sync_a: assert property (mode_cmd_valid_in
		&& mode_cmd_value_in == 8'h04 |=> sync
		&& pins_oe_out == $past(mode_cmd_mask_in)) else $error("sync mode");

	cover property (sync && h2d_take_out);
	cover property (send_immediate_out);
	cover property (!pin_update_strobe_n_out && !sync);
endmodule // cpp_channel_port_sva

bind cpp_channel_port cpp_channel_port_sva cpp_channel_port_sva_i (.*);

// ### sim/cpp_cpu_model.sv
// External CPU model that works the port's select, strobe and data pins.
module cpp_cpu_model (
	// Clock and the port's pin drive.
	input wire logic clk_in,
	input wire logic [7:0] dev_pins_in,
	// Bus control and the CPU's own drive of the data pins.
	output logic port_select_n_out,
	output logic register_select_out,
	output logic read_n_out,
	output logic write_n_out,
	output logic [7:0] ext_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus: deselected, strobes high.
	initial begin
		port_select_n_out = 1;
		register_select_out = 0;
		read_n_out = 1;
		write_n_out = 1;
		ext_out = 8'h5A;
	end

	// One cycle; a strobe stays low over three clocks and select holds two more, and a released
	// bus shows the inverse pattern so stale data never looks valid.
	task automatic access(input logic cs, rs, wr, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_in) #1;
		port_select_n_out = !cs;
		register_select_out = rs;
		ext_out = wr ? d : ~ext_out;
		read_n_out = wr;
		write_n_out = !wr;
		repeat (3) @(posedge clk_in);
		q = dev_pins_in;
		#1;
		read_n_out = 1;
		write_n_out = 1;
		repeat (2) @(posedge clk_in);
		#1;
		port_select_n_out = 1;
		ext_out = ~d;
	endtask
endmodule // cpp_cpu_model

// ### sim/cpp_channel_port_tb.sv
// Self-checking bench for the channel parallel port.
module cpp_channel_port_tb import cpp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, reset_n_in = 0, cfg = 1, hv = 0, sp = 1, mv = 0;
	logic tick = 0, susp = 0, conf = 1, utx = 0, fw = 1;
	logic sel_n, rs, rd_n, wr_n, take, dv, si, txoe, rxoe, txl;
	logic [7:0] hd = 0, mval = 0, mmask = 0, ext, q, pout, poe, ddat;
	cpp_mode_type mode;
	int error_cnt = 0, n_tests = 0, cyc = 0, flushes = 0;
	logic [7:0] got[$];

	cpp_channel_port #(.LED_HOLD_CYCLES(8)) cpp_channel_port_i (.clk_in,
		.reset_n_in, .cfg_cpu_fifo_in(cfg), .h2d_valid_in(hv),
		.h2d_data_in(hd), .h2d_take_out(take), .d2h_space_in(sp),
		.d2h_valid_out(dv), .d2h_data_out(ddat), .send_immediate_out(si),
		.mode_cmd_valid_in(mv), .mode_cmd_value_in(mval),
		.mode_cmd_mask_in(mmask), .baud_tick_in(tick), .suspended_in(susp),
		.configured_in(conf), .uart_tx_active_in(utx),
		.uart_rx_active_in(utx), .port_select_n_in(sel_n),
		.register_select_in(rs), .read_n_in(rd_n), .write_n_in(wr_n),
		.flush_wake_n_in(fw), .pins_in(poe & pout | ~poe & ext),
		.pins_out(pout), .pins_oe_out(poe), .pin_sample_strobe_n_out(),
		.pin_update_strobe_n_out(), .tx_led_out(txl), .tx_led_oe_out(txoe),
		.rx_led_out(), .rx_led_oe_out(rxoe), .mode_out(mode));
	cpp_cpu_model cpp_cpu_model_i (.clk_in, .dev_pins_in(pout),
		.port_select_n_out(sel_n), .register_select_out(rs),
		.read_n_out(rd_n), .write_n_out(wr_n), .ext_out(ext));

	initial forever #20 clk_in = ~clk_in;

	// Collect host-bound bytes and flushes; a hang ends the run as a fail.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (dv === 1'b1) got.push_back(ddat);
		if (si === 1'b1) flushes++;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, act);
		n_tests++;
		if (exp !== act) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, act);
		end
	endtask

	task automatic give_verdict();
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmd(input logic [7:0] v, m);
		@(posedge clk_in) #1;
		mv = 1;
		mval = v;
		mmask = m;
		@(posedge clk_in) #1;
		mv = 0;
		@(posedge clk_in) #1;
	endtask

	// Offer one host byte and withdraw it on the edge that consumes it.
	task automatic host(input logic [7:0] d);
		int n;
		hv = 1;
		hd = d;
		for (n = 0; n < 30 && take !== 1'b1; n++) @(posedge clk_in) #1;
		chk("host take", 8'h01, {7'h0, take});
		hv = 0;
		repeat (5) @(posedge clk_in);
		#1;
	endtask

	initial begin
		repeat (12) @(posedge clk_in);
		#1 reset_n_in = 1;
		repeat (3) @(posedge clk_in) #1;
		chk("strap mode", 8'(CPP_MODE_CPU_FIFO), 8'(mode));
		hv = 1;
		hd = 8'hA5;
		cpp_cpu_model_i.access(1, 1, 0, 0, q);
		chk("status", 8'h0B, q);
		cpp_cpu_model_i.access(1, 0, 0, 0, q);
		chk("read pipe", 8'hA5, q);
		hv = 0;
		sp = 0;
		susp = 1;
		conf = 0;
		cpp_cpu_model_i.access(1, 1, 0, 0, q);
		chk("status", 8'h04, q);
		sp = 1;
		susp = 0;
		conf = 1;
		cpp_cpu_model_i.access(0, 0, 1, 8'h3C, q);
		cpp_cpu_model_i.access(0, 1, 1, 8'h00, q);
		cpp_cpu_model_i.access(1, 0, 1, 8'hC3, q);
		cpp_cpu_model_i.access(1, 1, 1, 8'h00, q);
		fw = 0;
		repeat (3) @(posedge clk_in);
		#1 fw = 1;
		repeat (3) @(posedge clk_in);
		chk("pushes", 8'h01, 8'(got.size()));
		chk("pushed", 8'hC3, got.pop_front());
		chk("flushes", 8'h02, 8'(flushes));
		cmd(8'h04, 8'h0F);
		chk("sync mode", 8'(CPP_MODE_SYNC_BB), 8'(mode));
		chk("direction", 8'h0F, poe);
		sp = 0;
		hv = 1;
		hd = 8'h55;
		repeat (6) @(posedge clk_in) #1;
		chk("no room", 8'h00, {7'h0, take});
		sp = 1;
		host(8'h55);
		host(8'hAA);
		host(8'hAA);
		chk("lag one", 8'hF5, got[1]);
		chk("lag two", 8'hFA, got[2]);
		chk("sync pins", 8'hAA, pout);
		cmd(8'h01, 8'hFF);
		hv = 1;
		hd = 8'h96;
		repeat (4) @(posedge clk_in) #1;
		chk("no tick", 8'hAA, pout);
		tick = 1;
		repeat (2) @(posedge clk_in) #1 tick = 0;
		hv = 0;
		chk("async out", 8'h96, pout);
		chk("async sample", 8'hAA, got[3]);
		tick = 1;
		repeat (3) @(posedge clk_in) #1 tick = 0;
		chk("async hold", 8'h96, pout);
		cmd(8'h02, 8'h00);
		chk("ignored", 8'(CPP_MODE_ASYNC_BB), 8'(mode));
		cmd(8'h00, 8'h00);
		chk("back", 8'(CPP_MODE_CPU_FIFO), 8'(mode));
		reset_n_in = 0;
		cfg = 0;
		repeat (2) @(posedge clk_in);
		#1 reset_n_in = 1;
		repeat (3) @(posedge clk_in) #1 utx = 1;
		chk("uart mode", 8'(CPP_MODE_UART), 8'(mode));
		@(posedge clk_in) #1 utx = 0;
		@(posedge clk_in) #1;
		chk("tx lit", 8'h01, {7'h0, txoe});
		chk("rx lit", 8'h01, {7'h0, rxoe});
		chk("tx level", 8'h00, {7'h0, txl});
		repeat (14) @(posedge clk_in) #1;
		chk("tx dark", 8'h00, {7'h0, txoe});
		chk("rx dark", 8'h00, {7'h0, rxoe});
		give_verdict();
	end
endmodule // cpp_channel_port_tb
